// [design/tcp_pkg.sv]
// Package for the timer start and PWM block: register map, fields, reset values.
// Assumes a single 125 MHz clock domain and a plain strobe register port.
package tcp_pkg;
   localparam int          AW           = 4;
   localparam logic [3:0]  OFF_CTRL     = 4'h0;  // Run bits, source selects, PWM
   localparam logic [3:0]  OFF_PS_DATA  = 4'h1;  // Prescaler count and reload
   localparam logic [3:0]  OFF_T1_CNT   = 4'h2;
   localparam logic [3:0]  OFF_T1_RLD   = 4'h3;
   localparam logic [3:0]  OFF_T2_CNT   = 4'h4;
   localparam logic [3:0]  OFF_T2_RLD   = 4'h5;  // High interval reload
   localparam logic [3:0]  OFF_T2_HRLD  = 4'h6;
   localparam logic [3:0]  OFF_T3_RLD   = 4'h7;
   localparam logic [3:0]  OFF_T4_CNT   = 4'h8;
   localparam logic [3:0]  OFF_T4_RLD   = 4'h9;
   localparam logic [3:0]  OFF_IRQ_STAT = 4'ha;
   localparam logic [3:0]  OFF_IRQ_MASK = 4'hb;
   localparam logic [3:0]  OFF_PORTC    = 4'hc;
   // Control register fields
   localparam int CTL_PS_RUN  = 0;
   localparam int CTL_T1_RUN  = 1;
   localparam int CTL_T2_RUN  = 2;
   localparam int CTL_T3_RUN  = 3;
   localparam int CTL_T4_RUN  = 4;
   localparam int CTL_T1_COUNTER_PIN = 5;  // Timer one counts the counter pin
   localparam int CTL_T2_SRC  = 6;  // Timer two: 0 internal count source, 1 timer one underflow
   localparam int CTL_T3_SRC  = 7;  // Timer three: 0 prescaler, 1 timer two underflow
   localparam int CTL_T4_SRC  = 8;  // Fourth timer: 0 prescaler, 1 raw clock divided
   localparam int CTL_PWM_EN  = 9;
   localparam int CTL_PWM_EXT = 10; // Low interval extension
   localparam int CTL_W       = 11;
   // Event bits
   localparam int EV_PS = 0;
   localparam int EV_T1 = 1;
   localparam int EV_T2 = 2;
   localparam int EV_T3 = 3;
   localparam int EV_T4 = 4;
   localparam int EV_W  = 5;
   localparam logic [31:0] RST_ZERO = 32'h0000_0000;
   localparam logic [7:0]  RST_RLD  = 8'hff;
   localparam logic [7:0]  PS_SRC_DIV = 8'h03; // Internal count source divider
endpackage : tcp_pkg

// [design/tcp_cnt_if.sv]
// Interface carrying one counter's controls and status.
// Assumes the top instantiates one per timer in the mclk domain.
`timescale 1ns/1ps
interface tcp_cnt_if;
   logic       run;       // Timer enabled by firmware
   logic       src_rise;  // Count source rising edge
   logic       src_fall;  // Count source falling edge
   logic       fall_arm;  // Wait for a falling edge before starting
   logic       wr;        // Direct count write
   logic [7:0] wdata;     // Count write data
   logic [7:0] reload;    // Reload value
   logic [7:0] count;     // Present count
   logic       uflow;     // Underflow pulse
   modport ctl (output run, src_rise, src_fall, fall_arm, wr, wdata, reload,
                input count, uflow);
   modport cnt (input run, src_rise, src_fall, fall_arm, wr, wdata, reload,
                output count, uflow);
endinterface : tcp_cnt_if

// [design/tcp_counter.sv]
// One down counter with start alignment and reload on underflow.
// Assumes edge pulses are single mclk cycles from the top.
`timescale 1ns/1ps
module tcp_counter (
   input  wire logic mclk,       // System clock
   input  wire logic rst_n,      // Synchronised reset
   tcp_cnt_if.cnt    bus         // Controls and status
);
   logic       armed_ff;
   logic       seen_fall_ff;
   logic [7:0] cnt_ff;
   logic       uf_ff;
   wire        go_edge   = bus.run & bus.src_rise;
   wire        may_count = armed_ff & go_edge & (~bus.fall_arm | seen_fall_ff);
   wire        at_zero   = (cnt_ff == 8'h00);
   assign bus.count = cnt_ff;
   assign bus.uflow = uf_ff;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         armed_ff     <= 1'b0;
         seen_fall_ff <= 1'b0;
         cnt_ff       <= tcp_pkg::RST_RLD;
         uf_ff        <= 1'b0;
      end else begin
         armed_ff <= bus.run;                              // RULE_01
         if (!bus.run)
            seen_fall_ff <= 1'b0;
         else if (bus.src_fall)
            seen_fall_ff <= 1'b1;                          // RULE_04
         uf_ff <= may_count & at_zero;                     // RULE_16
         if (bus.wr)
            cnt_ff <= bus.wdata;
         else if (may_count)
            cnt_ff <= at_zero ? bus.reload : cnt_ff - 8'h01; // RULE_16 RULE_02 RULE_05
      end
   end
endmodule : tcp_counter

// [design/tcp_timers.sv]
// Prescaler, timers one to three, fourth timer, PWM and interrupt logic.
// Assumes a single mclk domain; counter pin is asynchronous.
// Behaviour
// RULE_01: Count only after first source rising edge
// RULE_02: First underflow may be one period short
// RULE_03: Counter pin source counts on falling edges
// RULE_04: Timer two/fourth start after falling, rising
// RULE_05: First underflow interval of those may differ
// RULE_06: Firmware halts timers before source change
// RULE_07: Firmware halts timer three before source change
// RULE_08: Firmware halts prescaler before read or write
// RULE_09: Firmware halts timer one/two before reading
// RULE_10: Firmware halts timers before writing counts
// RULE_11: Firmware avoids reload write at underflow
// RULE_12: Firmware avoids stopping PWM at underflow
// RULE_13: Extension needs high reload of one+
// RULE_14: Firmware clears port C latch for PWM
// RULE_15: Port C high output still drives pin
// RULE_16: Underflow reloads, continues, raises event
`timescale 1ns/1ps
module tcp_timers (
   input  wire logic        mclk,        // 125 MHz clock
   input  wire logic        arst_n,      // Async reset, active low
   input  wire logic [3:0]  addr,        // Register index
   input  wire logic [31:0] wdata,       // Write data
   input  wire logic        wr,          // Write strobe
   input  wire logic        rd,          // Read strobe
   output logic      [31:0] rdata,       // Read data, cycle after rd
   input  wire logic        counter_pin_i, // Counter pin input level
   output logic             counter_pin_o, // Counter pin output level
   output logic             counter_pin_oe, // Counter pin drive enable
   output logic             irq          // Level interrupt
);
   logic [1:0]  rst_sync_ff;
   wire         rst_n = rst_sync_ff[1];
   logic [2:0]  pin_sync_ff;
   logic        pin_state_ff;
   logic [tcp_pkg::CTL_W-1:0] ctrl_ff;
   logic [7:0]  ps_cnt_ff, ps_rld_ff, t1_rld_ff, t2_rld_ff, t2_hrld_ff;
   logic [7:0]  t3_rld_ff, t4_rld_ff;
   logic [7:0]  div_ff;
   logic        src_lvl_ff;
   logic [tcp_pkg::EV_W-1:0] stat_ff, mask_ff;
   logic        portc_ff;
   logic        pwm_ff;
   logic        pwm_hi_ff;
   logic [31:0] rdata_ff;

   function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
      hit = (a == off);
   endfunction : hit

   // Two-flop reset release
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n)
         rst_sync_ff <= 2'b00;
      else
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
   end

   // Internal count source: divided clock as a square wave
   wire src_toggle = (div_ff == tcp_pkg::PS_SRC_DIV);
   wire src_rise   = src_toggle & ~src_lvl_ff;
   wire src_fall   = src_toggle & src_lvl_ff;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         div_ff     <= 8'h00;
         src_lvl_ff <= 1'b0;
      end else begin
         div_ff     <= src_toggle ? 8'h00 : div_ff + 8'h01;
         src_lvl_ff <= src_lvl_ff ^ src_toggle;
      end
   end

   // Counter pin: three flops, change accepted when the last two agree
   wire pin_agree = (pin_sync_ff[1] == pin_sync_ff[2]);
   wire pin_fall  = pin_agree & pin_state_ff & ~pin_sync_ff[2];
   wire pin_rise  = pin_agree & ~pin_state_ff & pin_sync_ff[2];
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pin_sync_ff  <= 3'b000;
         pin_state_ff <= 1'b0;
      end else begin
         pin_sync_ff <= {pin_sync_ff[1:0], counter_pin_i};
         if (pin_agree)
            pin_state_ff <= pin_sync_ff[2];
      end
   end

   // Register decode
   wire wr_ctrl  = wr & hit(addr, tcp_pkg::OFF_CTRL);
   wire wr_ps    = wr & hit(addr, tcp_pkg::OFF_PS_DATA);
   wire wr_t1    = wr & hit(addr, tcp_pkg::OFF_T1_CNT);
   wire wr_t2    = wr & hit(addr, tcp_pkg::OFF_T2_CNT);
   wire wr_t4    = wr & hit(addr, tcp_pkg::OFF_T4_CNT);
   wire wr_stat  = wr & hit(addr, tcp_pkg::OFF_IRQ_STAT);

   tcp_cnt_if t1_if ();
   tcp_cnt_if t2_if ();
   tcp_cnt_if t3_if ();
   tcp_cnt_if t4_if ();

   // Prescaler: counts source rising edges after start
   logic ps_armed_ff, ps_uf_ff;
   wire  ps_go = ps_armed_ff & ctrl_ff[tcp_pkg::CTL_PS_RUN] & src_rise; // RULE_01
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ps_cnt_ff   <= tcp_pkg::RST_RLD;
         ps_armed_ff <= 1'b0;
         ps_uf_ff    <= 1'b0;
      end else begin
         ps_armed_ff <= ctrl_ff[tcp_pkg::CTL_PS_RUN];
         ps_uf_ff    <= ps_go & (ps_cnt_ff == 8'h00);
         if (wr_ps)
            ps_cnt_ff <= wdata[7:0];
         else if (ps_go)
            ps_cnt_ff <= (ps_cnt_ff == 8'h00) ? ps_rld_ff : ps_cnt_ff - 8'h01; // RULE_16
      end
   end

   wire t1_counter_pin = ctrl_ff[tcp_pkg::CTL_T1_COUNTER_PIN];
   assign t1_if.run      = ctrl_ff[tcp_pkg::CTL_T1_RUN];
   assign t1_if.src_rise = t1_counter_pin ? pin_fall : ps_uf_ff;  // RULE_03
   assign t1_if.src_fall = t1_counter_pin ? pin_rise : 1'b0;
   assign t1_if.fall_arm = 1'b0;
   assign t1_if.wr       = wr_t1;
   assign t1_if.wdata    = wdata[7:0];
   assign t1_if.reload   = t1_rld_ff;

   wire t2_alt = ctrl_ff[tcp_pkg::CTL_T2_SRC];
   assign t2_if.run      = ctrl_ff[tcp_pkg::CTL_T2_RUN];
   assign t2_if.src_rise = t2_alt ? t1_if.uflow : src_rise;
   assign t2_if.src_fall = t2_alt ? t1_if.uflow : src_fall;
   assign t2_if.fall_arm = 1'b1;                             // RULE_04
   assign t2_if.wr       = wr_t2;
   assign t2_if.wdata    = wdata[7:0];
   assign t2_if.reload   = pwm_hi_ff ? t2_hrld_ff : t2_rld_ff;

   assign t3_if.run      = ctrl_ff[tcp_pkg::CTL_T3_RUN];
   assign t3_if.src_rise = ctrl_ff[tcp_pkg::CTL_T3_SRC] ? t2_if.uflow : ps_uf_ff;
   assign t3_if.src_fall = 1'b0;
   assign t3_if.fall_arm = 1'b0;
   assign t3_if.wr       = 1'b0;
   assign t3_if.wdata    = 8'h00;
   assign t3_if.reload   = t3_rld_ff;

   assign t4_if.run      = ctrl_ff[tcp_pkg::CTL_T4_RUN];
   assign t4_if.src_rise = ctrl_ff[tcp_pkg::CTL_T4_SRC] ? src_rise : ps_uf_ff;
   assign t4_if.src_fall = ctrl_ff[tcp_pkg::CTL_T4_SRC] ? src_fall : ps_uf_ff;
   assign t4_if.fall_arm = 1'b1;                             // RULE_04
   assign t4_if.wr       = wr_t4;
   assign t4_if.wdata    = wdata[7:0];
   assign t4_if.reload   = t4_rld_ff;

   tcp_counter u_t1 (.mclk(mclk), .rst_n(rst_n), .bus(t1_if.cnt));
   tcp_counter u_t2 (.mclk(mclk), .rst_n(rst_n), .bus(t2_if.cnt));
   tcp_counter u_t3 (.mclk(mclk), .rst_n(rst_n), .bus(t3_if.cnt));
   tcp_counter u_t4 (.mclk(mclk), .rst_n(rst_n), .bus(t4_if.cnt));

   // PWM toggles on each timer two underflow; the low phase uses the high reload
   wire pwm_on = ctrl_ff[tcp_pkg::CTL_PWM_EN] & ctrl_ff[tcp_pkg::CTL_PWM_EXT];
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pwm_ff    <= 1'b0;
         pwm_hi_ff <= 1'b0;
      end else if (!ctrl_ff[tcp_pkg::CTL_PWM_EN]) begin
         pwm_ff    <= 1'b0;
         pwm_hi_ff <= 1'b0;
      end else if (t2_if.uflow) begin
         pwm_ff    <= ~pwm_ff;
         pwm_hi_ff <= pwm_on & ~pwm_ff;
      end
   end

   // Port C high level and PWM both reach the pin
   assign counter_pin_o  = portc_ff | (ctrl_ff[tcp_pkg::CTL_PWM_EN] & pwm_ff); // RULE_15
   assign counter_pin_oe = portc_ff | ctrl_ff[tcp_pkg::CTL_PWM_EN];

   wire [tcp_pkg::EV_W-1:0] events = {t4_if.uflow, t3_if.uflow, t2_if.uflow,
                                      t1_if.uflow, ps_uf_ff};
   wire [tcp_pkg::EV_W-1:0] clr    = wr_stat ? wdata[tcp_pkg::EV_W-1:0] : '0;
   assign irq = |(stat_ff & mask_ff);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_ff    <= '0;
         ps_rld_ff  <= tcp_pkg::RST_RLD;
         t1_rld_ff  <= tcp_pkg::RST_RLD;
         t2_rld_ff  <= tcp_pkg::RST_RLD;
         t2_hrld_ff <= tcp_pkg::RST_RLD;
         t3_rld_ff  <= tcp_pkg::RST_RLD;
         t4_rld_ff  <= tcp_pkg::RST_RLD;
         stat_ff    <= '0;
         mask_ff    <= '0;
         portc_ff   <= 1'b0;
      end else begin
         if (wr_ctrl)                                     ctrl_ff    <= wdata[tcp_pkg::CTL_W-1:0];
         if (wr_ps)                                       ps_rld_ff  <= wdata[15:8];
         if (wr & hit(addr, tcp_pkg::OFF_T1_RLD))         t1_rld_ff  <= wdata[7:0];
         if (wr & hit(addr, tcp_pkg::OFF_T2_RLD))         t2_rld_ff  <= wdata[7:0];
         if (wr & hit(addr, tcp_pkg::OFF_T2_HRLD))        t2_hrld_ff <= wdata[7:0];
         if (wr & hit(addr, tcp_pkg::OFF_T3_RLD))         t3_rld_ff  <= wdata[7:0];
         if (wr & hit(addr, tcp_pkg::OFF_T4_RLD))         t4_rld_ff  <= wdata[7:0];
         if (wr & hit(addr, tcp_pkg::OFF_IRQ_MASK))       mask_ff    <= wdata[tcp_pkg::EV_W-1:0];
         if (wr & hit(addr, tcp_pkg::OFF_PORTC))          portc_ff   <= wdata[0];
         stat_ff <= (stat_ff & ~clr) | events;             // RULE_16
      end
   end

   // Read mux, data in the following cycle
   logic [31:0] rmux;
   always_comb begin
      rmux = tcp_pkg::RST_ZERO;
      unique case (addr)
         tcp_pkg::OFF_CTRL:     rmux[tcp_pkg::CTL_W-1:0] = ctrl_ff;
         tcp_pkg::OFF_PS_DATA:  rmux[15:0] = {ps_rld_ff, ps_cnt_ff};
         tcp_pkg::OFF_T1_CNT:   rmux[7:0]  = t1_if.count;
         tcp_pkg::OFF_T1_RLD:   rmux[7:0]  = t1_rld_ff;
         tcp_pkg::OFF_T2_CNT:   rmux[7:0]  = t2_if.count;
         tcp_pkg::OFF_T2_RLD:   rmux[7:0]  = t2_rld_ff;
         tcp_pkg::OFF_T2_HRLD:  rmux[7:0]  = t2_hrld_ff;
         tcp_pkg::OFF_T3_RLD:   rmux[7:0]  = t3_rld_ff;
         tcp_pkg::OFF_T4_CNT:   rmux[7:0]  = t4_if.count;
         tcp_pkg::OFF_T4_RLD:   rmux[7:0]  = t4_rld_ff;
         tcp_pkg::OFF_IRQ_STAT: rmux[tcp_pkg::EV_W-1:0] = stat_ff;
         tcp_pkg::OFF_IRQ_MASK: rmux[tcp_pkg::EV_W-1:0] = mask_ff;
         tcp_pkg::OFF_PORTC:    rmux[0]    = portc_ff;
         default:               rmux = tcp_pkg::RST_ZERO;
      endcase
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         rdata_ff <= tcp_pkg::RST_ZERO;
      else
         rdata_ff <= rd ? rmux : tcp_pkg::RST_ZERO;
   end
   assign rdata = rdata_ff;
endmodule : tcp_timers

// [test/tcp_pin_model.sv]
// Model of the outside device driving the counter pin.
// Assumes one fire request per pin pulse; the pin rests low.
`timescale 1ns/1ps
module tcp_pin_model (
   input  wire logic mclk, // Clock
   input  wire logic fire, // Request one pulse
   output logic      pin   // Pin level
);
   logic [2:0] n_ff = 3'h0;
   // Rising edge first, then the falling edge that counts
   always_ff @(posedge mclk) begin
      if (fire) n_ff <= 3'h6;
      else if (n_ff != 3'h0) n_ff <= n_ff - 3'h1;
   end
   assign pin = n_ff != 3'h0;
endmodule : tcp_pin_model

// [test/tcp_timers_chk.sv]
// Checker on the top ports of tcp_timers: bus, pin and interrupt.
// Assumes register writes only after reset release; bound below.
`timescale 1ns/1ps
module tcp_timers_chk (
   input wire logic        mclk,           // Clock
   input wire logic        arst_n,         // Async reset
   input wire logic [3:0]  addr,           // Register index
   input wire logic [31:0] wdata,          // Write data
   input wire logic        wr,             // Write strobe
   input wire logic        rd,             // Read strobe
   input wire logic [31:0] rdata,          // Read data
   input wire logic        counter_pin_o,  // Pin level
   input wire logic        counter_pin_oe, // Pin enable
   input wire logic        irq             // Interrupt
);
   logic       latch_ff;
   logic       pwm_ff;
   logic [4:0] mask_ff;
   wire        wr_ctl  = wr && addr == tcp_pkg::OFF_CTRL;
   wire        wr_pc   = wr && addr == tcp_pkg::OFF_PORTC;
   wire        wr_mask = wr && addr == tcp_pkg::OFF_IRQ_MASK;
   // Shadows of the registers that steer pin and irq
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         latch_ff <= 1'b0;
         pwm_ff   <= 1'b0;
         mask_ff  <= 5'h0;
      end else begin
         if (wr_pc) latch_ff <= wdata[0];
         if (wr_ctl) pwm_ff <= wdata[tcp_pkg::CTL_PWM_EN];
         if (wr_mask) mask_ff <= wdata[4:0];
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!arst_n);
   rd_idle_a: assert property (!rd |=> rdata == 32'h0)
      else $error("read data not zero outside read answer");
   unmapped_rd_a: assert property (rd && addr > tcp_pkg::OFF_PORTC |=> rdata == 32'h0)
      else $error("unmapped read not zero");
   pin_oe_a: assert property (counter_pin_o |-> counter_pin_oe)
      else $error("pin high without enable");
   latch_pin_a: assert property (latch_ff |-> counter_pin_o && counter_pin_oe)
      else $error("port latch high not on pin");
   idle_oe_a: assert property (!latch_ff && !pwm_ff |-> !counter_pin_oe)
      else $error("pin driven with latch and pwm off");
   irq_mask_a: assert property (mask_ff == 5'h0 |-> !irq)
      else $error("irq with all events masked");
   irq_sticky_a: assert property (irq && !wr |=> irq)
      else $error("irq dropped without a write");
   pwm_hold_a: assert property ((!pwm_ff && !wr) [*3] |=> $stable(counter_pin_o))
      else $error("pin moved with pwm off");
   irq_c: cover property ($rose(irq));
   pwm_c: cover property (pwm_ff && !latch_ff && $rose(counter_pin_o));
   cnt_rd_c: cover property (rd && addr == tcp_pkg::OFF_T1_CNT);
endmodule : tcp_timers_chk

bind tcp_timers tcp_timers_chk chk (.mclk(mclk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
   .wr(wr), .rd(rd), .rdata(rdata), .counter_pin_o(counter_pin_o),
   .counter_pin_oe(counter_pin_oe), .irq(irq));

// [test/tcp_timers_bench.sv]
// Self-checking bench for tcp_timers: registers, start timing, pin, irq.
// Assumes the design, pin model and checker are compiled first.
`timescale 1ns/1ps
module tcp_timers_bench;
   logic        mclk;
   logic        arst_n;
   logic [3:0]  addr;
   logic [31:0] wdata;
   logic        wr;
   logic        rd;
   logic        fire;
   logic        rd_q;
   logic        last;
   logic [31:0] rdata;
   logic        pin_o;
   logic        pin_oe;
   logic        ext_pin;
   logic        irq;
   logic [31:0] seed;
   logic [31:0] exp_q[$];
   string       name_q[$];
   int          error_cnt;
   int          n_compared;
   int          cyc;
   int          tog;
   wire         pin_w = pin_oe ? pin_o : ext_pin;
   tcp_timers dut (.mclk(mclk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .counter_pin_i(pin_w), .counter_pin_o(pin_o), .counter_pin_oe(pin_oe),
      .irq(irq));
   tcp_pin_model ext (.mclk(mclk), .fire(fire), .pin(ext_pin));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic wreg(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge mclk);
      wr    <= 1'b0;
   endtask : wreg
   task automatic rreg(input logic [3:0] a, input logic [31:0] e, input string what);
      @(posedge mclk);
      addr <= a;
      rd   <= 1'b1;
      exp_q.push_back(e);
      name_q.push_back(what);
      @(posedge mclk);
      rd   <= 1'b0;
   endtask : rreg
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   // Look only after the clock edge has settled, so a clear just issued is seen
   task automatic wait_irq(output int t);
      int n;
      n = 0;
      do begin
         @(negedge mclk);
         n++;
      end while (irq !== 1'b1 && n < 400);
      t = cyc;
      check({31'h0, irq}, 32'h1, "irq raised");
   endtask : wait_irq
   task automatic pulses(input int k);
      repeat (k) begin
         @(posedge mclk);
         fire <= 1'b1;
         @(posedge mclk);
         fire <= 1'b0;
         repeat (14) @(posedge mclk);
      end
   endtask : pulses
   // Source set while halted, then start; first and steady underflow spacing
   task automatic ivl(input logic [31:0] ctl, input int ev);
      int t0;
      int ta;
      int tb;
      int tc;
      wreg(tcp_pkg::OFF_IRQ_MASK, 32'h1 << ev);
      wreg(tcp_pkg::OFF_CTRL, ctl & 32'h7e0);
      wreg(tcp_pkg::OFF_CTRL, ctl);
      t0 = cyc;
      wait_irq(ta);
      wreg(tcp_pkg::OFF_IRQ_STAT, 32'h1f);
      wait_irq(tb);
      wreg(tcp_pkg::OFF_IRQ_STAT, 32'h1f);
      wait_irq(tc);
      check(32'(tc - tb), 32'h10, "steady interval");
      check({31'h0, ta - t0 >= 8 && ta - t0 <= 40}, 32'h1, "first interval");
      wreg(tcp_pkg::OFF_CTRL, 32'h0);
      wreg(tcp_pkg::OFF_IRQ_STAT, 32'h1f);
      $display("interval test done for event %0d", ev);
   endtask : ivl
   task automatic test_done;
      $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : test_done
   always @(posedge mclk) rd_q <= rd;
   always @(posedge mclk) cyc <= cyc + 1;
   always @(negedge mclk) begin
      if (rd_q && exp_q.size() > 0) check(rdata, exp_q.pop_front(), name_q.pop_front());
   end
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   initial begin
      repeat (20000) @(posedge mclk);
      error_cnt++;
      test_done();
   end
   initial begin
      arst_n = 1'b0;
      addr = 4'h0;
      wdata = 32'h0;
      wr = 1'b0;
      rd = 1'b0;
      fire = 1'b0;
      cyc = 0;
      seed = 32'h6a49dc47;
      repeat (10) @(posedge mclk);
      arst_n <= 1'b1;
      repeat (3) @(posedge mclk);
      for (int a = 0; a < 16; a++) begin
         rreg(4'(a), a == 1 ? 32'hffff : (a >= 2 && a <= 9) ? 32'hff : 32'h0, "reset value");
      end
      for (int a = 3; a < 8; a++) begin
         seed = lfsr(seed);
         wreg(4'(a), {24'h0, seed[7:0] | 8'h01});
         rreg(4'(a), {24'h0, seed[7:0] | 8'h01}, "reload");
      end
      wreg(4'he, seed);
      rreg(4'he, 32'h0, "unmapped");
      $display("register test done");
      wreg(tcp_pkg::OFF_PS_DATA, 32'h0101);
      ivl(32'h1 << tcp_pkg::CTL_PS_RUN, tcp_pkg::EV_PS);
      wreg(tcp_pkg::OFF_T4_RLD, 32'h1);
      wreg(tcp_pkg::OFF_T4_CNT, 32'h1);
      ivl(32'h1 << tcp_pkg::CTL_T4_SRC | 32'h1 << tcp_pkg::CTL_T4_RUN, tcp_pkg::EV_T4);
      wreg(tcp_pkg::OFF_T1_RLD, 32'h2);
      wreg(tcp_pkg::OFF_T1_CNT, 32'h2);
      wreg(tcp_pkg::OFF_IRQ_MASK, 32'h1 << tcp_pkg::EV_T1);
      wreg(tcp_pkg::OFF_CTRL, 32'h1 << tcp_pkg::CTL_T1_COUNTER_PIN);
      wreg(tcp_pkg::OFF_CTRL, 32'h1 << tcp_pkg::CTL_T1_COUNTER_PIN | 32'h1 << tcp_pkg::CTL_T1_RUN);
      pulses(2);
      wreg(tcp_pkg::OFF_CTRL, 32'h1 << tcp_pkg::CTL_T1_COUNTER_PIN);
      rreg(tcp_pkg::OFF_T1_CNT, 32'h0, "pin count");
      rreg(tcp_pkg::OFF_IRQ_STAT, 32'h0, "no event yet");
      wreg(tcp_pkg::OFF_CTRL, 32'h1 << tcp_pkg::CTL_T1_COUNTER_PIN | 32'h1 << tcp_pkg::CTL_T1_RUN);
      pulses(1);
      wreg(tcp_pkg::OFF_CTRL, 32'h1 << tcp_pkg::CTL_T1_COUNTER_PIN);
      rreg(tcp_pkg::OFF_T1_CNT, 32'h2, "reloaded count");
      rreg(tcp_pkg::OFF_IRQ_STAT, 32'h1 << tcp_pkg::EV_T1, "event bit");
      wreg(tcp_pkg::OFF_IRQ_MASK, 32'h0);
      @(negedge mclk);
      check({31'h0, irq}, 32'h0, "masked irq");
      wreg(tcp_pkg::OFF_IRQ_STAT, 32'h1 << tcp_pkg::EV_T1);
      rreg(tcp_pkg::OFF_IRQ_STAT, 32'h0, "cleared");
      $display("counter pin test done");
      wreg(tcp_pkg::OFF_PORTC, 32'h1);
      @(negedge mclk);
      check({30'h0, pin_o, pin_oe}, 32'h3, "latch drive");
      wreg(tcp_pkg::OFF_PORTC, 32'h0);
      wreg(tcp_pkg::OFF_PS_DATA, 32'h0);
      wreg(tcp_pkg::OFF_T2_CNT, 32'h1);
      wreg(tcp_pkg::OFF_T2_RLD, 32'h1);
      wreg(tcp_pkg::OFF_T2_HRLD, 32'h1);
      wreg(tcp_pkg::OFF_CTRL, 32'h1 << tcp_pkg::CTL_PWM_EN);
      wreg(tcp_pkg::OFF_CTRL, 32'h607);
      tog = 0;
      last = pin_o;
      for (int i = 0; i < 200; i++) begin
         @(negedge mclk);
         if (pin_o !== last) tog++;
         last = pin_o;
      end
      check({31'h0, tog >= 6 && pin_oe === 1'b1}, 32'h1, "pwm toggles");
      @(negedge mclk iff pin_o !== last);
      wreg(tcp_pkg::OFF_T2_HRLD, 32'h2);
      wreg(tcp_pkg::OFF_CTRL, 32'h0);
      $display("pwm test done");
      repeat (4) @(posedge mclk);
      test_done();
   end
endmodule : tcp_timers_bench
